/* common/snz_pkg.sv */
// Purpose: Shared constants and types of the standby sequencer control.
// Assumes: APB register bus with 32-bit data and one word per register.
// Notes: Power modes and sequencer states are one-hot.
package snz_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned MEM_AW = 16;
   localparam int unsigned INT_W = 4;
   localparam int unsigned CTRL_W = 5;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_MEMWIN = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_STATE = 12'h010;
   ////////////////////////////////////////////////////////////////////////////
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_LPC_BIT = 1;
   localparam int unsigned CTRL_SRC_LSB = 2;
   localparam int unsigned CTRL_STOP_BIT = 4;
   localparam int unsigned INT_END_BIT = 0;
   localparam int unsigned INT_REFUSE_BIT = 1;
   localparam int unsigned INT_BLOCK_BIT = 2;
   localparam int unsigned INT_DONE_BIT = 3;
   localparam int unsigned STATE_SEQ_LSB = 4;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   localparam logic [INT_W-1:0] STAT_RST = 4'h0;
   localparam logic [INT_W-1:0] MASK_RST = 4'hf;
   localparam logic [MEM_AW-1:0] MEMWIN_RST = 16'h0400;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [1:0] CLK_HIGH_OSC = 2'h0;
   localparam logic [1:0] CLK_MID_OSC = 2'h1;
   localparam logic [1:0] CLK_SUB = 2'h2;
   localparam logic [1:0] CLK_OTHER = 2'h3;
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      SNZ_RUN = 4'b0001,
      SNZ_HALT = 4'b0010,
      SNZ_STOP = 4'b0100,
      SNZ_SNOOZE = 4'b1000
   } snz_mode_t;
   typedef enum logic [2:0] {
      SEQ_STOPPED = 3'b001,
      SEQ_WAIT = 3'b010,
      SEQ_OPER = 3'b100
   } snz_seq_state_t;
   typedef struct packed {
      logic trig;
      logic term;
      logic mask_wr0;
   } snz_seq_evt_t;
   typedef struct packed {
      logic req;
      logic [MEM_AW-1:0] addr;
   } snz_mem_req_t;
endpackage

/* logic/snz_seq_fsm.sv */
// Purpose: State of the snooze sequencer: stopped, waiting, operating.
// Assumes: Events are one-cycle pulses synchronous to clk.
// Notes: The state holds while allowed is low, unless force_stop or a low run_en sends it to stopped.
`timescale 1ns/1ns
module snz_seq_fsm (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic run_en,
   input wire logic force_stop,
   input wire logic allowed,
   input wire logic trig_ok,
   input wire logic term,
   output snz_pkg::snz_seq_state_t state,
   output logic done
);
   snz_pkg::snz_seq_state_t next_state;

   always_comb begin
      next_state = state;
      if (force_stop || !run_en) begin
         next_state = snz_pkg::SEQ_STOPPED;
      end else if (allowed) begin
         unique case (state)
            snz_pkg::SEQ_STOPPED: next_state = snz_pkg::SEQ_WAIT;
            snz_pkg::SEQ_WAIT: begin
               if (trig_ok) begin
                  next_state = snz_pkg::SEQ_OPER;
               end
            end
            snz_pkg::SEQ_OPER: begin
               if (term) begin
                  next_state = snz_pkg::SEQ_WAIT; // [R10]
               end
            end
            default: next_state = snz_pkg::SEQ_STOPPED;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= snz_pkg::SEQ_STOPPED;
      end else if (ce) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         done <= 1'b0;
      end else if (ce) begin
         done <= (state == snz_pkg::SEQ_OPER) &&
                 (next_state == snz_pkg::SEQ_WAIT); // [R11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   term_to_wait_a: assert property ( // [R10]
      ce && state == snz_pkg::SEQ_OPER && term && allowed && run_en &&
      !force_stop |=> state == snz_pkg::SEQ_WAIT && done)
      else $error("Termination did not reach the waiting state.");
   done_pulse_a: assert property ( // [R11]
      ce && done |=> !done)
      else $error("Completion indication longer than one cycle.");
endmodule // snz_seq_fsm

/* logic/snz_standby_ctrl.sv */
// Purpose: Standby interaction of the snooze sequencer with power modes.
// Assumes: All inputs synchronous to clk; APB slave with zero wait states.
// Notes: The sequencer engine itself sits outside and reports events.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
// Behaviour
// R1 - Halt keeps the sequencer on, unless subsystem clock and low-power bit.
// R2 - In stop the selected activating trigger is still accepted.
// R3 - A trigger in stop enters snooze; completion returns the chip to stop.
// R4 - Snooze is entered only with the high or middle speed oscillator.
// R5 - In snooze, sequencer accesses beyond the window are blocked.
// R6 - Masked clocked serial trigger: program wakes CPU or re-arms reception.
// R7 - Masked async serial trigger: program wakes CPU or re-arms reception.
// R8 - Masked converter trigger: program wakes CPU or re-arms its wakeup.
// R9 - Sequencer clearing its end mask sets the end flag and raises interrupt.
// R10 - The termination command returns the sequencer to trigger waiting.
// R11 - A one-cycle completion pulse lets snooze fall back to stop.
module snz_standby_ctrl (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [snz_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_halt_req,
   input wire logic cpu_stop_req,
   input wire logic cpu_wake_irq,
   input wire snz_pkg::snz_seq_evt_t seq_evt,
   input wire snz_pkg::snz_mem_req_t seq_mem,
   output logic mem_grant,
   output logic mem_blocked,
   output snz_pkg::snz_mode_t power_mode,
   output snz_pkg::snz_seq_state_t seq_state,
   output logic seq_done,
   output logic seq_end_interrupt,
   output logic irq
);
   logic [snz_pkg::CTRL_W-1:0] ctrl;
   logic [snz_pkg::MEM_AW-1:0] memwin;
   logic [snz_pkg::INT_W-1:0] int_stat;
   logic [snz_pkg::INT_W-1:0] int_mask;
   logic wr;
   logic rd_setup;
   logic mapped;
   logic force_stop;
   logic [1:0] clk_src;
   logic clk_ok;
   logic seq_allowed;
   logic trig_ok;
   logic refused;
   logic wake;
   logic end_set;
   logic [snz_pkg::INT_W-1:0] stat_set;
   snz_pkg::snz_mode_t next_mode;

   function automatic logic hit(input logic [snz_pkg::ADDR_W-1:0] a,
                                input logic [snz_pkg::ADDR_W-1:0] off);
      hit = (a[snz_pkg::ADDR_W-1:2] == off[snz_pkg::ADDR_W-1:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register bus.
   assign wr = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable;
   assign mapped = hit(paddr, snz_pkg::OFF_CTRL) ||
                   hit(paddr, snz_pkg::OFF_MEMWIN) ||
                   hit(paddr, snz_pkg::OFF_INT_STAT) ||
                   hit(paddr, snz_pkg::OFF_INT_MASK) ||
                   hit(paddr, snz_pkg::OFF_STATE);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign force_stop = wr && hit(paddr, snz_pkg::OFF_CTRL) &&
                       pwdata[snz_pkg::CTRL_STOP_BIT];

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (ce && rd_setup) begin
         prdata <= 32'h0000_0000;
         if (hit(paddr, snz_pkg::OFF_CTRL)) begin
            prdata[snz_pkg::CTRL_STOP_BIT-1:0] <=
               ctrl[snz_pkg::CTRL_STOP_BIT-1:0];
         end else if (hit(paddr, snz_pkg::OFF_MEMWIN)) begin
            prdata[snz_pkg::MEM_AW-1:0] <= memwin;
         end else if (hit(paddr, snz_pkg::OFF_INT_STAT)) begin
            prdata[snz_pkg::INT_W-1:0] <= int_stat;
         end else if (hit(paddr, snz_pkg::OFF_INT_MASK)) begin
            prdata[snz_pkg::INT_W-1:0] <= int_mask;
         end else if (hit(paddr, snz_pkg::OFF_STATE)) begin
            prdata[3:0] <= power_mode;
            prdata[snz_pkg::STATE_SEQ_LSB+2:snz_pkg::STATE_SEQ_LSB] <=
               seq_state;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= snz_pkg::CTRL_RST;
      end else if (ce && force_stop) begin
         ctrl <= snz_pkg::CTRL_RST;
      end else if (ce && wr && hit(paddr, snz_pkg::OFF_CTRL)) begin
         ctrl <= {1'b0, pwdata[snz_pkg::CTRL_STOP_BIT-1:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         memwin <= snz_pkg::MEMWIN_RST;
      end else if (ce && wr && hit(paddr, snz_pkg::OFF_MEMWIN)) begin
         memwin <= pwdata[snz_pkg::MEM_AW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock and mode conditions.
   assign clk_src = ctrl[snz_pkg::CTRL_SRC_LSB+1:snz_pkg::CTRL_SRC_LSB];
   assign clk_ok = (clk_src == snz_pkg::CLK_HIGH_OSC) ||
                   (clk_src == snz_pkg::CLK_MID_OSC); // [R4]
   assign seq_allowed = !(power_mode == snz_pkg::SNZ_HALT &&
                          clk_src == snz_pkg::CLK_SUB &&
                          ctrl[snz_pkg::CTRL_LPC_BIT]); // [R1]
   assign trig_ok = seq_evt.trig && seq_allowed &&
                    (power_mode != snz_pkg::SNZ_STOP || clk_ok); // [R2] [R4]
   assign refused = seq_evt.trig && power_mode == snz_pkg::SNZ_STOP &&
                    !clk_ok && seq_state == snz_pkg::SEQ_WAIT; // [R4]
   assign wake = cpu_wake_irq || irq;

   snz_seq_fsm u_seq (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .run_en(ctrl[snz_pkg::CTRL_RUN_BIT]),
      .force_stop(force_stop),
      .allowed(seq_allowed),
      .trig_ok(trig_ok),
      .term(seq_evt.term),
      .state(seq_state),
      .done(seq_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Power mode.
   always_comb begin
      next_mode = power_mode;
      unique case (power_mode)
         snz_pkg::SNZ_RUN: begin
            if (cpu_stop_req) begin
               next_mode = snz_pkg::SNZ_STOP;
            end else if (cpu_halt_req) begin
               next_mode = snz_pkg::SNZ_HALT;
            end
         end
         snz_pkg::SNZ_HALT: begin
            if (wake) begin
               next_mode = snz_pkg::SNZ_RUN;
            end
         end
         snz_pkg::SNZ_STOP: begin
            if (wake) begin
               next_mode = snz_pkg::SNZ_RUN;
            end else if (trig_ok && seq_state == snz_pkg::SEQ_WAIT) begin
               next_mode = snz_pkg::SNZ_SNOOZE; // [R3]
            end
         end
         snz_pkg::SNZ_SNOOZE: begin
            if (wake) begin
               next_mode = snz_pkg::SNZ_RUN; // [R6] [R7] [R8]
            end else if (seq_done || seq_state == snz_pkg::SEQ_STOPPED) begin
               next_mode = snz_pkg::SNZ_STOP; // [R3] [R11]
            end
         end
         default: next_mode = snz_pkg::SNZ_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         power_mode <= snz_pkg::SNZ_RUN;
      end else if (ce) begin
         power_mode <= next_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory window in snooze.
   always_ff @(posedge clk) begin
      if (srst) begin
         mem_grant <= 1'b0;
         mem_blocked <= 1'b0;
      end else if (ce) begin
         mem_blocked <= seq_mem.req && power_mode == snz_pkg::SNZ_SNOOZE &&
                        seq_mem.addr >= memwin; // [R5]
         mem_grant <= seq_mem.req && !(power_mode == snz_pkg::SNZ_SNOOZE &&
                      seq_mem.addr >= memwin); // [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts.
   assign end_set = seq_evt.mask_wr0 && seq_state == snz_pkg::SEQ_OPER;
   assign stat_set = {seq_done, mem_blocked, refused, end_set};

   always_ff @(posedge clk) begin
      if (srst) begin
         int_stat <= snz_pkg::STAT_RST;
      end else if (ce) begin
         if (wr && hit(paddr, snz_pkg::OFF_INT_STAT)) begin
            int_stat <= (int_stat & ~pwdata[snz_pkg::INT_W-1:0]) | stat_set;
         end else begin
            int_stat <= int_stat | stat_set; // [R9]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         int_mask <= snz_pkg::MASK_RST;
      end else if (ce) begin
         if (wr && hit(paddr, snz_pkg::OFF_INT_MASK)) begin
            int_mask <= pwdata[snz_pkg::INT_W-1:0];
         end
         if (end_set) begin
            int_mask[snz_pkg::INT_END_BIT] <= 1'b0; // [R9]
         end
      end
   end

   assign seq_end_interrupt = int_stat[snz_pkg::INT_END_BIT] &&
                              !int_mask[snz_pkg::INT_END_BIT]; // [R9]
   assign irq = |(int_stat & ~int_mask);

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   halt_sub_block_a: assert property ( // [R1]
      power_mode == snz_pkg::SNZ_HALT && clk_src == snz_pkg::CLK_SUB &&
      ctrl[snz_pkg::CTRL_LPC_BIT] |-> !trig_ok)
      else $error("Trigger taken in halt on low-power subsystem clock.");
   stop_trig_take_a: assert property ( // [R2]
      ce && power_mode == snz_pkg::SNZ_STOP && seq_evt.trig && clk_ok &&
      seq_state == snz_pkg::SEQ_WAIT && ctrl[snz_pkg::CTRL_RUN_BIT] &&
      !force_stop && !wake
      |=> power_mode == snz_pkg::SNZ_SNOOZE &&
          seq_state == snz_pkg::SEQ_OPER)
      else $error("Trigger in stop did not start the sequencer in snooze.");
   snooze_return_a: assert property ( // [R3]
      ce && power_mode == snz_pkg::SNZ_SNOOZE && seq_done && !wake
      |=> power_mode == snz_pkg::SNZ_STOP)
      else $error("Completion in snooze did not return to stop.");
   snooze_refuse_a: assert property ( // [R4]
      ce && power_mode == snz_pkg::SNZ_STOP && !clk_ok
      |=> power_mode != snz_pkg::SNZ_SNOOZE)
      else $error("Snooze entered on a disallowed clock source.");
   refuse_flag_a: assert property ( // [R4]
      ce && refused |=> int_stat[snz_pkg::INT_REFUSE_BIT])
      else $error("Refused snooze entry not flagged.");
   mem_block_a: assert property ( // [R5]
      ce && seq_mem.req && power_mode == snz_pkg::SNZ_SNOOZE &&
      seq_mem.addr >= memwin |=> !mem_grant && mem_blocked)
      else $error("Access outside the snooze window was granted.");
   end_flag_set_a: assert property ( // [R9]
      ce && end_set |=> int_stat[snz_pkg::INT_END_BIT] &&
      !int_mask[snz_pkg::INT_END_BIT] && seq_end_interrupt && irq)
      else $error("Mask write of zero did not raise the end interrupt.");
endmodule // snz_standby_ctrl

/* verif/snz_seq_engine_model.sv */
// Purpose: Behavioural sequencer engine facing the standby control.
// Assumes: Events are one-cycle pulses launched just after a rising edge.
// Notes: A released memory address shows the inverse of its last value.
`timescale 1ns/1ns
module snz_seq_engine_model (
   input wire logic clk,
   output snz_pkg::snz_seq_evt_t evt,
   output snz_pkg::snz_mem_req_t mem
);
   initial begin
      evt = '0;
      mem = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Drives one event pulse for one cycle and lets its effect land.
   task automatic pulse(input logic [2:0] e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      #1;
   endtask
   // Makes one memory access request for one cycle.
   task automatic access(input logic [snz_pkg::MEM_AW-1:0] a);
      @(posedge clk);
      mem <= '{req: 1'b1, addr: a};
      @(posedge clk);
      mem <= '{req: 1'b0, addr: ~a};
      #1;
   endtask
   // Ends a program, waking the processor first when asked to.
   task automatic finish(input logic wake);
      if (wake) begin
         pulse(3'b001);
      end
      pulse(3'b010);
   endtask
endmodule // snz_seq_engine_model

/* verif/testbench.sv */
// Purpose: Self-checking bench of the standby sequencer control.
// Assumes: APB master and engine model change inputs just after rising edges.
// Notes: Tests are sequences of bus and event calls.
`timescale 1ns/1ns
module testbench;
   logic clk, srst, ce, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic halt_q, stop_q, wake_q, mem_grant, mem_blocked, seq_done, sei, irq;
   logic e;
   snz_pkg::snz_seq_evt_t evt;
   snz_pkg::snz_mem_req_t mem;
   snz_pkg::snz_mode_t mode;
   snz_pkg::snz_seq_state_t st;
   int fail_count = 0;
   int checks = 0;
   snz_standby_ctrl u_dut (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_halt_req(halt_q), .cpu_stop_req(stop_q), .cpu_wake_irq(wake_q),
      .seq_evt(evt), .seq_mem(mem), .mem_grant(mem_grant),
      .mem_blocked(mem_blocked), .power_mode(mode), .seq_state(st),
      .seq_done(seq_done), .seq_end_interrupt(sei), .irq(irq));
   snz_seq_engine_model u_eng (.clk(clk), .evt(evt), .mem(mem));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] got,
                      input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, r, exp);
   endtask
   task automatic cpu(input logic [2:0] q);
      @(posedge clk);
      {halt_q, stop_q, wake_q} <= q;
      @(posedge clk);
      {halt_q, stop_q, wake_q} <= 3'h0;
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      tally_and_finish;
   end
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      {halt_q, stop_q, wake_q} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rdc("ctrl", 12'h000, 32'h0000_0000);
      rdc("memwin", 12'h004, 32'h0000_0400);
      rdc("stat", 12'h008, 32'h0000_0000);
      rdc("mask", 12'h00c, 32'h0000_000f);
      rdc("state", 12'h010, {snz_pkg::SEQ_STOPPED, snz_pkg::SNZ_RUN});
      rdc("unmapped", 12'h020, 32'h0000_0000);
      chk("slverr", e, 1'b1);
      chk("ready", pready, 1'b1);
      $display("test reset done");
      apb(1'b1, 12'h000, 32'h0000_0005);
      cpu(3'b010);
      chk("seq wait", st, snz_pkg::SEQ_WAIT);
      chk("stop", mode, snz_pkg::SNZ_STOP);
      u_eng.pulse(3'b100);
      chk("snooze", mode, snz_pkg::SNZ_SNOOZE);
      chk("oper", st, snz_pkg::SEQ_OPER);
      u_eng.access(16'h0500);
      chk("blocked", {mem_grant, mem_blocked}, 2'b01);
      u_eng.access(16'h03ff);
      chk("granted", {mem_grant, mem_blocked}, 2'b10);
      u_eng.finish(1'b0);
      chk("term", {st, seq_done}, {snz_pkg::SEQ_WAIT, 1'b1});
      @(posedge clk);
      #1;
      chk("back", {mode, seq_done}, {snz_pkg::SNZ_STOP, 1'b0});
      rdc("stat", 12'h008, 32'h0000_000c);
      apb(1'b1, 12'h008, 32'h0000_000c);
      rdc("cleared", 12'h008, 32'h0000_0000);
      $display("test snooze round done");
      apb(1'b1, 12'h000, 32'h0000_0009);
      u_eng.pulse(3'b100);
      chk("refused", {mode, st},
          {snz_pkg::SNZ_STOP, snz_pkg::SEQ_WAIT});
      rdc("refuse flag", 12'h008, 32'h0000_0002);
      chk("masked irq", irq, 1'b0);
      apb(1'b1, 12'h00c, 32'h0000_000d);
      #1;
      chk("irq", irq, 1'b1);
      apb(1'b1, 12'h008, 32'h0000_0002);
      #1;
      chk("irq clear", irq, 1'b0);
      apb(1'b1, 12'h00c, 32'h0000_000f);
      $display("test refusal done");
      cpu(3'b001);
      cpu(3'b100);
      chk("halt", mode, snz_pkg::SNZ_HALT);
      apb(1'b1, 12'h000, 32'h0000_000b);
      u_eng.pulse(3'b100);
      chk("halt lpc", st, snz_pkg::SEQ_WAIT);
      apb(1'b1, 12'h000, 32'h0000_0009);
      u_eng.pulse(3'b100);
      chk("halt run", {mode, st},
          {snz_pkg::SNZ_HALT, snz_pkg::SEQ_OPER});
      u_eng.finish(1'b0);
      chk("halt term", st, snz_pkg::SEQ_WAIT);
      $display("test halt done");
      apb(1'b1, 12'h008, 32'h0000_000f);
      apb(1'b1, 12'h000, 32'h0000_0001);
      cpu(3'b001);
      cpu(3'b010);
      u_eng.pulse(3'b100);
      chk("snooze high", mode, snz_pkg::SNZ_SNOOZE);
      u_eng.finish(1'b1);
      chk("wake", {sei, irq, mode}, {2'b11, snz_pkg::SNZ_RUN});
      rdc("end mask", 12'h00c, 32'h0000_000e);
      rdc("end flag", 12'h008, 32'h0000_0009);
      $display("test wake done");
      apb(1'b1, 12'h008, 32'h0000_000f);
      apb(1'b1, 12'h00c, 32'h0000_000f);
      @(posedge clk);
      ce <= 1'b0;
      cpu(3'b010);
      apb(1'b1, 12'h004, 32'h0000_0200);
      chk("frozen mode", mode, snz_pkg::SNZ_RUN);
      @(posedge clk);
      ce <= 1'b1;
      rdc("frozen memwin", 12'h004, 32'h0000_0400);
      $display("test freeze done");
      apb(1'b1, 12'h004, 32'h0000_0200);
      rdc("memwin", 12'h004, 32'h0000_0200);
      cpu(3'b010);
      u_eng.pulse(3'b100);
      chk("snooze again", mode, snz_pkg::SNZ_SNOOZE);
      u_eng.access(16'h0300);
      chk("window", {mem_grant, mem_blocked}, 2'b01);
      apb(1'b1, 12'h000, 32'h0000_0010);
      @(posedge clk);
      #1;
      chk("forced", {mode, st},
          {snz_pkg::SNZ_STOP, snz_pkg::SEQ_STOPPED});
      rdc("forced ctrl", 12'h000, 32'h0000_0000);
      $display("test force stop done");
      tally_and_finish;
   end
endmodule // testbench
